//--- rtl/irq_prio_pkg.sv
// Constants shared by the interrupt prioritizer and its helpers.
// Assumes a 32-bit APB slave on pclk, one word per register.

package irq_prio_pkg;

	// ****************************************************************
	// Source counts and widths
	// ****************************************************************
	localparam int N_PERIPH    = 15;    // Peripheral source identifiers 0..14
	localparam int N_LEVEL     = 12;    // User-defined priority levels
	localparam int N_FLAG      = 16;    // General flag pins
	localparam int N_VEC       = 17;    // Fixed vectors plus user levels
	localparam int LVL_W       = 4;     // Width of one level field
	localparam int VEC_W       = 5;     // Width of a vector number

	// ****************************************************************
	// Vector numbers: fixed sources first, in priority order
	// ****************************************************************
	localparam logic [4:0] VEC_RESET = 5'h00;  // Reset interrupt
	localparam logic [4:0] VEC_PDOWN = 5'h01;  // Power-down interrupt
	localparam logic [4:0] VEC_EMU   = 5'h02;  // External emulator
	localparam logic [4:0] VEC_KERN  = 5'h03;  // Emulator kernel
	localparam logic [4:0] VEC_STACK = 5'h04;  // Stack interrupt
	localparam logic [4:0] VEC_USER0 = 5'h05;  // First user level
	localparam logic [4:0] VEC_NONE  = 5'h1F;  // Nothing selected

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CONTROL = 8'h00;  // interrupt_control
	localparam logic [7:0] OFS_MASK    = 8'h04;  // interrupt mask
	localparam logic [7:0] OFS_LATCH   = 8'h08;  // latch read
	localparam logic [7:0] OFS_FORCE   = 8'h0C;  // latch force (w1s)
	localparam logic [7:0] OFS_CLEAR   = 8'h10;  // latch clear (w1c)
	localparam logic [7:0] OFS_PRIO0   = 8'h14;  // Ids 0..7, 4 bits each
	localparam logic [7:0] OFS_PRIO1   = 8'h18;  // Ids 8..14
	localparam logic [7:0] OFS_FLAGDIR = 8'h1C;  // Flag pin 1 = output
	localparam logic [7:0] OFS_FLAGOUT = 8'h20;  // Flag pin out value
	localparam logic [7:0] OFS_FLAGMOD = 8'h24;  // 2 bits per pin
	localparam logic [7:0] OFS_FLAGAB  = 8'h28;  // [15:0] grp A,[31:16] B
	localparam logic [7:0] OFS_STATUS  = 8'h2C;  // Selected vector, state
	localparam logic [7:0] OFS_ISTAT   = 8'h30;  // Sticky events, w1c
	localparam logic [7:0] OFS_INTERRUPT_MASK_REGISTER   = 8'h34;  // Event irq mask

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int CTL_NEST = 4;  // Nesting enable
	localparam int CTL_GIE  = 5;  // Global enable
	localparam logic [15:0] CTL_RW_MASK = 16'h0030;  // Writable bits
	localparam logic [15:0] CTL_RESET   = 16'h0000;  // Servicing off

	// ****************************************************************
	// Flag pin trigger modes
	// ****************************************************************
	typedef enum logic [1:0] {
		TRIG_LEVEL = 2'h0,  // High level
		TRIG_RISE  = 2'h1,  // Rising edge
		TRIG_FALL  = 2'h2,  // Falling edge
		TRIG_BOTH  = 2'h3   // Either edge
	} trig_mode_e;

	// Reset level map: id n -> n for 0..11, ids 12..14 -> 11
	localparam logic [31:0] PRIO0_RESET = 32'h7654_3210;
	localparam logic [31:0] PRIO1_RESET = 32'h0BBB_BA98;
	localparam logic [31:0] MASK_RESET  = 32'h0000_0000;

endpackage : irq_prio_pkg

//--- rtl/flag_pin_detect.sv
// One flag pin: input synchroniser and trigger detector.
// Assumes the pin is asynchronous to pclk.

`timescale 1ns/10ps
`default_nettype none

module flag_pin_detect (
	input  wire logic       pclk,     // Core clock
	input  wire logic       presetn,  // Async reset, active low
	input  wire logic       pin_in,   // Raw pin level
	input  wire logic       is_out,   // Pin configured as output
	input  wire logic       out_val,  // Driven value when output
	input  wire logic [1:0] mode,     // Trigger mode
	output logic            req_lvl,  // Level request
	output logic            req_edge  // One-cycle edge event
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic s1;     // First sync stage
		logic s2;     // Second sync stage
		logic s3;     // Third sync stage
		logic level;  // Agreed level
	} det_s;

	det_s state_reg;   // Registered state
	det_s state_next;  // Next state
	logic src;         // Selected source
	logic prev;        // Level before update

	// Output pins raise software interrupts off their own value
	assign src = is_out ? out_val : pin_in;

	// ****************************************************************
	// Sync, agree, detect
	// ****************************************************************
	always_comb begin
		state_next    = state_reg;
		state_next.s1 = src;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		prev          = state_reg.level;
		// Change counts once two late stages agree
		if (state_reg.s2 == state_reg.s3) begin
			state_next.level = state_reg.s3;
		end
	end

	always_comb begin
		req_lvl  = 1'b0;
		req_edge = 1'b0;
		unique case (irq_prio_pkg::trig_mode_e'(mode))
			irq_prio_pkg::TRIG_LEVEL: req_lvl = state_reg.level;
			irq_prio_pkg::TRIG_RISE:
				req_edge = state_next.level & ~prev;
			irq_prio_pkg::TRIG_FALL:
				req_edge = ~state_next.level & prev;
			irq_prio_pkg::TRIG_BOTH:
				req_edge = state_next.level ^ prev;
		endcase
	end

	// Register the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : flag_pin_detect

`default_nettype wire

//--- rtl/prio_select.sv
// Priority picker: lowest set index of a request vector wins.
// Pure combinational, used on the core clock.

`timescale 1ns/10ps
`default_nettype none

module prio_select (
	input  wire logic [16:0] req,    // Qualified requests
	output logic             found,  // Any request present
	output logic [4:0]       index   // Winning index
);

	// ****************************************************************
	// Scan from the top so the lowest index is kept last
	// ****************************************************************
	always_comb begin
		found = 1'b0;
		index = irq_prio_pkg::VEC_NONE;
		for (int i = 16; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				index = 5'(i);
			end
		end
	end

endmodule : prio_select

`default_nettype wire

//--- rtl/dsp_interrupt_prioritizer.sv
// Interrupt prioritizer with APB registers and flag pin inputs.
// Assumes the core sequencer acknowledges with a vector number and
// signals return from a handler; peripherals give level requests.
//
// How it works
// - Seventeen sources: five fixed, twelve user levels.
// - Each peripheral maps to any user level.
// - Ids 0..11 reset to own level.
// - Ids 12..14 reset to level 11.
// - Each latched request ANDed with mask bit.
// - Only highest priority unmasked request presented.
// - Mask ignores emulation, power-down, reset.
// - Disable instruction blocks power-down interrupt.
// - Nested preempts, sequential waits for finish.
// - Control register holds nesting and global enable.
// - Flag pins raise software and hardware interrupts.
// - Flag trigger: level, single edge, both.
// - Enable/disable instructions gate servicing globally; reset and external emulator vectors still pass while disabled.
// - Servicing disabled after reset.
// - Latch register forces and clears pending.
//
// The address map and the APB slave port were left to the implementer.

`timescale 1ns/10ps
`default_nettype none

module dsp_interrupt_prioritizer (
	input  wire logic        pclk,          // Core clock, 50 MHz
	input  wire logic        presetn,       // Async reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB access phase
	input  wire logic        pwrite,        // APB direction
	input  wire logic [7:0]  paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic [31:0]      prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	input  wire logic [14:0] periph_req,    // Peripheral requests by id
	input  wire logic        stack_req,     // Stack level event
	input  wire logic        kernel_req,    // Emulator kernel event
	input  wire logic        pdown_req,     // Power-down event
	input  wire logic        emu_req,       // External emulator event
	input  wire logic        reset_req,     // Reset interrupt event
	input  wire logic [15:0] flag_pin_in,   // general_flag_pin inputs
	output logic [15:0]      flag_pin_out,  // general_flag_pin outputs
	output logic [15:0]      flag_pin_oe_n, // Low while driving
	input  wire logic        enable_interrupts_instruction,       // enable_interrupts_instruction
	input  wire logic        disable_interrupts_instruction,       // disable_interrupts_instruction
	input  wire logic        irq_ack,       // Core takes vector
	input  wire logic        irq_return,    // Core ends a handler
	output logic             irq_valid,     // Vector offered to core
	output logic [4:0]       irq_vector,    // Offered vector
	output logic             irq            // Event interrupt, level
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [15:0] ctl;        // interrupt_control_register
		logic [16:0] mask;       // interrupt_mask_register
		logic [16:0] latch;      // interrupt_latch_register
		logic [31:0] prio0;      // Level map ids 0..7
		logic [31:0] prio1;      // Level map ids 8..14
		logic [15:0] fdir;       // Flag direction
		logic [15:0] fout;       // Flag output value
		logic [31:0] fmode;      // Flag trigger modes
		logic [31:0] fgrp;       // Flag group enables
		logic [16:0] active;     // Handlers in service
		logic [4:0]  vec;        // Registered vector
		logic        vld;        // Registered valid
		logic [1:0]  istat;      // Sticky events: ack, return
		logic [1:0]  interrupt_mask_register;      // Event mask
		logic [31:0] rdata;      // Read data
	} ctl_s;

	ctl_s        st_reg;       // Registered state
	ctl_s        st_next;      // Next state
	logic [15:0] f_lvl;        // Flag level requests
	logic [15:0] f_edge;       // Flag edge events
	logic [14:0] src_lvl;      // Level requests by id
	logic [14:0] src_edge;     // Edge events by id
	logic [16:0] set_vec;      // Latch set this cycle
	logic [16:0] cand;         // Masked candidates
	logic [16:0] gated;        // After nesting gate
	logic        found;        // Any candidate
	logic [4:0]  win;          // Winner index
	logic        wr;           // APB write strobe
	logic        rd;           // APB read strobe
	logic        hit;          // Mapped address

	// ****************************************************************
	// Flag pins, one detector each
	// ****************************************************************
	// pins as sources
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_flag
			flag_pin_detect u_det (
				.pclk     (pclk),
				.presetn  (presetn),
				.pin_in   (flag_pin_in[g]),
				.is_out   (st_reg.fdir[g]),
				.out_val  (st_reg.fout[g]),
				.mode     (st_reg.fmode[2*g +: 2]),
				.req_lvl  (f_lvl[g]),
				.req_edge (f_edge[g])
			);
		end
	endgenerate

	// Pins face out only when set as outputs
	assign flag_pin_out  = st_reg.fout;
	assign flag_pin_oe_n = ~st_reg.fdir;

	// Group A and B gather any enabled pin
	always_comb begin
		src_lvl       = periph_req;
		src_edge      = '0;
		src_lvl[12]   = |(f_lvl & st_reg.fgrp[15:0]);
		src_lvl[13]   = |(f_lvl & st_reg.fgrp[31:16]);
		src_edge[12]  = |(f_edge & st_reg.fgrp[15:0]);
		src_edge[13]  = |(f_edge & st_reg.fgrp[31:16]);
	end

	// ****************************************************************
	// Request set vector per vector slot
	// ****************************************************************
	// seventeen slots
	always_comb begin
		set_vec = '0;
		set_vec[irq_prio_pkg::VEC_RESET] = reset_req;
		set_vec[irq_prio_pkg::VEC_PDOWN] = pdown_req;
		set_vec[irq_prio_pkg::VEC_EMU]   = emu_req;
		set_vec[irq_prio_pkg::VEC_KERN]  = kernel_req;
		set_vec[irq_prio_pkg::VEC_STACK] = stack_req;
		for (int i = 0; i < 15; i++) begin
			if (src_lvl[i] | src_edge[i]) begin
				if (i < 8) begin
					set_vec[5 + st_reg.prio0[4*i +: 4]] = 1'b1;
				end else begin
					set_vec[5 + st_reg.prio1[4*(i-8) +: 4]] = 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Qualify and pick
	// ****************************************************************
	always_comb begin
		cand = st_reg.latch & st_reg.mask;
		cand[irq_prio_pkg::VEC_RESET] = st_reg.latch[irq_prio_pkg::VEC_RESET];
		cand[irq_prio_pkg::VEC_EMU]   = st_reg.latch[irq_prio_pkg::VEC_EMU];
		cand[irq_prio_pkg::VEC_PDOWN] =
			st_reg.latch[irq_prio_pkg::VEC_PDOWN] &
			st_reg.ctl[irq_prio_pkg::CTL_GIE];
		if (!st_reg.ctl[irq_prio_pkg::CTL_GIE]) begin
			cand = cand & 17'h00007;
		end
		gated = '0;
		// nested: only higher than the best active
		for (int i = 0; i < 17; i++) begin
			if (st_reg.ctl[irq_prio_pkg::CTL_NEST]) begin
				gated[i] = cand[i] & ~|(st_reg.active & ((17'h1 << i) - 17'h1))
					& ~st_reg.active[i];
			end else begin
				gated[i] = cand[i] & ~|st_reg.active;
			end
		end
	end

	// lowest index wins, levels ordered by index
	prio_select u_sel (
		.req   (gated),
		.found (found),
		.index (win)
	);

	// ****************************************************************
	// APB decode, single wait-free access
	// ****************************************************************
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign hit     = (paddr[1:0] == 2'h0) &&
		(paddr <= irq_prio_pkg::OFS_INTERRUPT_MASK_REGISTER);
	assign pslverr = psel & penable & ~hit;
	assign prdata  = st_reg.rdata;
	assign irq_valid  = st_reg.vld;
	assign irq_vector = st_reg.vec;
	assign irq = |(st_reg.istat & st_reg.interrupt_mask_register);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_next = st_reg;
		// sticky latch; set wins over clear below
		if (wr && paddr == irq_prio_pkg::OFS_CLEAR) begin
			st_next.latch = st_reg.latch & ~pwdata[16:0];
		end
		if (irq_ack && st_reg.vld) begin
			st_next.latch[st_reg.vec]  = 1'b0;
			st_next.active[st_reg.vec] = 1'b1;
			st_next.istat[0]           = 1'b1;
		end
		if (wr && paddr == irq_prio_pkg::OFS_FORCE) begin
			st_next.latch = st_next.latch | pwdata[16:0];
		end
		st_next.latch = st_next.latch | set_vec;
		// Return retires the best handler in service
		if (irq_return) begin
			for (int i = 16; i >= 0; i--) begin
				if (st_reg.active[i]) begin
					st_next.active = st_reg.active & ~(17'h1 << i);
				end
			end
			st_next.istat[1] = 1'b1;
		end
		if (wr && paddr == irq_prio_pkg::OFS_CONTROL) begin
			st_next.ctl = pwdata[15:0] & irq_prio_pkg::CTL_RW_MASK;
		end
		if (enable_interrupts_instruction) begin
			st_next.ctl[irq_prio_pkg::CTL_GIE] = 1'b1;
		end
		if (disable_interrupts_instruction) begin
			st_next.ctl[irq_prio_pkg::CTL_GIE] = 1'b0;
		end
		if (wr) begin
			unique case (paddr)
				irq_prio_pkg::OFS_MASK:    st_next.mask  = pwdata[16:0];
				irq_prio_pkg::OFS_PRIO0:   st_next.prio0 = pwdata;
				irq_prio_pkg::OFS_PRIO1:   st_next.prio1 = {4'h0, pwdata[27:0]};
				irq_prio_pkg::OFS_FLAGDIR: st_next.fdir  = pwdata[15:0];
				irq_prio_pkg::OFS_FLAGOUT: st_next.fout  = pwdata[15:0];
				irq_prio_pkg::OFS_FLAGMOD: st_next.fmode = pwdata;
				irq_prio_pkg::OFS_FLAGAB:  st_next.fgrp  = pwdata;
				irq_prio_pkg::OFS_INTERRUPT_MASK_REGISTER:   st_next.interrupt_mask_register = pwdata[1:0];
				default: ;
			endcase
		end
		// Event bits: set wins over write-one-clear
		if (wr && paddr == irq_prio_pkg::OFS_ISTAT) begin
			st_next.istat = st_next.istat & ~(pwdata[1:0] & ~{irq_return,
				irq_ack & st_reg.vld});
		end
		// Level map nibbles above 11 are clamped to 11
		for (int i = 0; i < 8; i++) begin
			if (st_next.prio0[4*i +: 4] > 4'hB) st_next.prio0[4*i +: 4] = 4'hB;
			if (i < 7 && st_next.prio1[4*i +: 4] > 4'hB)
				st_next.prio1[4*i +: 4] = 4'hB;
		end
		// Offer the winner; hold while unacknowledged
		st_next.vld = found && !(irq_ack && st_reg.vld);
		st_next.vec = found ? win : irq_prio_pkg::VEC_NONE;
		// Read data captured in setup phase
		if (rd) begin
			unique case (paddr)
				irq_prio_pkg::OFS_CONTROL: st_next.rdata = {16'h0, st_reg.ctl};
				irq_prio_pkg::OFS_MASK:    st_next.rdata = {15'h0, st_reg.mask};
				irq_prio_pkg::OFS_LATCH:   st_next.rdata = {15'h0, st_reg.latch};
				irq_prio_pkg::OFS_PRIO0:   st_next.rdata = st_reg.prio0;
				irq_prio_pkg::OFS_PRIO1:   st_next.rdata = st_reg.prio1;
				irq_prio_pkg::OFS_FLAGDIR: st_next.rdata = {16'h0, st_reg.fdir};
				irq_prio_pkg::OFS_FLAGOUT: st_next.rdata = {16'h0, st_reg.fout};
				irq_prio_pkg::OFS_FLAGMOD: st_next.rdata = st_reg.fmode;
				irq_prio_pkg::OFS_FLAGAB:  st_next.rdata = st_reg.fgrp;
				irq_prio_pkg::OFS_STATUS:
					st_next.rdata = {10'h0, st_reg.active, st_reg.vec};
				irq_prio_pkg::OFS_ISTAT:   st_next.rdata = {30'h0, st_reg.istat};
				irq_prio_pkg::OFS_INTERRUPT_MASK_REGISTER:   st_next.rdata = {30'h0, st_reg.interrupt_mask_register};
				default:                   st_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg       <= '0;
			st_reg.ctl   <= irq_prio_pkg::CTL_RESET;
			st_reg.prio0 <= irq_prio_pkg::PRIO0_RESET;
			st_reg.prio1 <= irq_prio_pkg::PRIO1_RESET;
			st_reg.mask  <= 17'h00000;
			st_reg.vec   <= irq_prio_pkg::VEC_NONE;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule : dsp_interrupt_prioritizer

`default_nettype wire

//--- tb/irq_prio_monitor.sv
// Port checker for the interrupt prioritizer.
// Bound into the top module; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module irq_prio_monitor (
	input wire logic        pclk,       // Clock
	input wire logic        presetn,    // Reset, low
	input wire logic        psel,       // Select
	input wire logic        penable,    // Access phase
	input wire logic        pwrite,     // Direction
	input wire logic [7:0]  paddr,      // Address
	input wire logic [31:0] prdata,     // Read data
	input wire logic        pready,     // Ready
	input wire logic        pslverr,    // Error
	input wire logic        irq_ack,    // Core take
	input wire logic        irq_return, // Handler end
	input wire logic        irq_valid,  // Vector offered
	input wire logic [4:0]  irq_vector, // Vector
	input wire logic        irq         // Event line
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr_take = psel && penable && pwrite;       // Write lands
	wire ev_any = irq_ack || irq_return || wr_take; // Event cause
	sequence access_s; psel && penable; endsequence
	sequence taken_s; irq_valid && irq_ack; endsequence

	ready_always_a: assert property (access_s |-> pready)
		else $error("Access not ready");
	err_decode_a: assert property (access_s |->
		pslverr == (paddr > 8'h34 || paddr[1:0] != 2'h0))
		else $error("Error flag wrong");
	err_setup_a: assert property (psel && !penable |-> !pslverr)
		else $error("Error in setup");
	// Read data only moves on a read setup
	rd_hold_a: assert property (!(psel && !penable && !pwrite)
		|=> $stable(prdata)) else $error("Read data moved");
	vec_range_a: assert property (irq_valid |-> irq_vector < 5'h11)
		else $error("Vector out of range");
	ack_drop_a: assert property (taken_s |=> !irq_valid)
		else $error("Valid held after ack");
	quiet_start_a: assert property ($rose(presetn) |->
		!irq_valid ##1 !irq_valid) else $error("Vector after reset");
	irq_fall_a: assert property ($fell(irq) |->
		$past(wr_take) || $past(wr_take, 2)) else $error("Irq fell");
	irq_rise_a: assert property ($rose(irq) |->
		$past(ev_any) || $past(ev_any, 2)) else $error("Irq rose");
endmodule // irq_prio_monitor
bind dsp_interrupt_prioritizer irq_prio_monitor mon (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.irq_ack, .irq_return, .irq_valid, .irq_vector, .irq);
`default_nettype wire

//--- tb/core_model.sv
// Core sequencer model: takes offered vectors, runs handlers.
// Shares pclk and presetn with the prioritizer.
`timescale 1ns/10ps
`default_nettype none
module core_model #(
	parameter int HOLD = 3                // Handler length, cycles
) (
	input  wire logic       pclk,         // Clock
	input  wire logic       presetn,      // Reset, low
	input  wire logic       irq_valid,    // Vector offered
	input  wire logic [4:0] irq_vector,   // Offered vector
	input  wire logic [3:0] ack_delay,    // Slowness of the take
	output logic            irq_ack,      // Take pulse
	output logic            irq_return,   // Handler end pulse
	output logic            taken,        // Vector accepted
	output logic [4:0]      taken_vec     // Accepted vector
);
	logic [3:0] wait_c; // Cycles waited
	logic [3:0] run_c;  // Handler cycles left
	// One handler at a time, so sequential order is visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack    <= 1'b0;
			irq_return <= 1'b0;
			wait_c     <= 4'h0;
			run_c      <= 4'h0;
		end else begin
			irq_ack    <= 1'b0;
			irq_return <= 1'b0;
			if (run_c != 4'h0) begin
				run_c      <= run_c - 4'h1;
				irq_return <= (run_c == 4'h1);
			end else if (irq_valid && !irq_ack) begin
				if (wait_c >= ack_delay) begin
					irq_ack <= 1'b1;
					wait_c  <= 4'h0;
					run_c   <= 4'(HOLD);
				end else begin
					wait_c <= wait_c + 4'h1;
				end
			end
		end
	end
	assign taken     = irq_ack && irq_valid;
	assign taken_vec = irq_vector;
endmodule // core_model
`default_nettype wire

//--- tb/tb_dsp_interrupt_prioritizer.sv
// Self-checking bench for the interrupt prioritizer.
// Drives APB and request pins; a core model takes vectors.
`timescale 1ns/10ps
`default_nettype none
`define chk(n, e, g) begin checked++; if ((g) !== (e)) begin \
	bad_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_dsp_interrupt_prioritizer;
	logic        pclk = 1'b0;    // 50 MHz clock
	logic        presetn = 1'b0; // Reset, low
	logic        psel = 1'b0;    // APB select
	logic        penable = 1'b0; // APB access
	logic        pwrite = 1'b0;  // APB direction
	logic [7:0]  paddr = 8'h00;  // APB address
	logic [31:0] pwdata = '0;    // APB write data
	logic [31:0] prdata;         // APB read data
	logic        pready, pslverr, err; // APB answer
	logic [14:0] preq = '0;      // Peripheral requests
	logic [3:0]  ev = 4'h0;      // pdown, reset, enable, disable
	logic [15:0] flag_in = '0;   // Flag pins
	logic [15:0] fo, foe;        // Flag pin out, enable
	logic        ack, ret, vld, irq, taken; // Core side
	logic [4:0]  vec, tvec, e_v; // Vectors
	logic [3:0]  dly = 4'h0;     // Core ack delay
	logic [31:0] rd, pw;         // Read and level words
	logic [14:0] m;              // Request set
	logic [4:0]  exp_q[$];       // Expected vectors
	int          bad_count = 0;  // Mismatches
	int          checked = 0;    // Comparisons
	int          seed = 61867;   // Random seed
	int          la, lb, ia, ib; // Levels and ids

	always #10 pclk = ~pclk;

	dsp_interrupt_prioritizer dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_req(preq), .stack_req(1'b0),
		.kernel_req(1'b0), .pdown_req(ev[3]), .emu_req(1'b0),
		.reset_req(ev[2]), .flag_pin_in(flag_in), .flag_pin_out(fo),
		.flag_pin_oe_n(foe), .enable_interrupts_instruction(ev[1]), .disable_interrupts_instruction(ev[0]),
		.irq_ack(ack), .irq_return(ret), .irq_valid(vld),
		.irq_vector(vec), .irq(irq));
	core_model core (.pclk(pclk), .presetn(presetn), .irq_valid(vld),
		.irq_vector(vec), .ack_delay(dly), .irq_ack(ack),
		.irq_return(ret), .taken(taken), .taken_vec(tvec));

	function automatic logic [4:0] uv(int l);
		return irq_prio_pkg::VEC_USER0 + 5'(l);
	endfunction

	task automatic test_done();
		$display("Checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One transfer; waits for pready, bounded
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(logic [7:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`chk("register", e, rd)
	endtask

	task automatic pulse(logic [14:0] p, logic [3:0] e);
		@(posedge pclk);
		preq <= p;
		ev   <= e;
		@(posedge pclk);
		preq <= '0;
		ev   <= 4'h0;
	endtask

	// Waits until every noted vector was taken
	task automatic drain();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 300) begin
			bad_count++;
			test_done();
		end
		repeat (8) @(posedge pclk);
	endtask

	// Each taken vector against the oldest note
	always @(posedge pclk) begin
		if (taken) begin
			if (exp_q.size() == 0) begin
				bad_count++;
				$display("Error vector exp none got %h", tvec);
			end else begin
				e_v = exp_q.pop_front();
				`chk("vector", e_v, tvec)
			end
		end
	end

	initial begin
		flag_in <= 16'($random(seed));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdc(irq_prio_pkg::OFS_CONTROL, 32'h0);
		rdc(irq_prio_pkg::OFS_PRIO0, irq_prio_pkg::PRIO0_RESET);
		rdc(irq_prio_pkg::OFS_PRIO1, irq_prio_pkg::PRIO1_RESET);
		apb(1'b0, 8'h38, 32'h0);
		`chk("unmapped err", 1'b1, err)
		`chk("unmapped data", 32'h0, rd)
		pulse(15'h0, 4'h8);
		exp_q.push_back(irq_prio_pkg::VEC_RESET);
		pulse(15'h0, 4'h4);
		drain();
		exp_q.push_back(irq_prio_pkg::VEC_PDOWN);
		pulse(15'h0, 4'h2);
		drain();
		apb(1'b1, irq_prio_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
		rdc(irq_prio_pkg::OFS_CONTROL, 32'h0000_0030);
		apb(1'b1, irq_prio_pkg::OFS_CONTROL, 32'h0000_0020);
		pulse(15'h0008, 4'h0);
		rdc(irq_prio_pkg::OFS_LATCH, 32'h0000_0100);
		exp_q.push_back(uv(3));
		apb(1'b1, irq_prio_pkg::OFS_MASK, 32'h0001_FFE0);
		drain();
		pulse(15'h0, 4'h1);
		apb(1'b1, irq_prio_pkg::OFS_FORCE, 32'h0000_0400);
		rdc(irq_prio_pkg::OFS_LATCH, 32'h0000_0400);
		apb(1'b1, irq_prio_pkg::OFS_CLEAR, 32'h0000_0400);
		rdc(irq_prio_pkg::OFS_LATCH, 32'h0);
		pulse(15'h0, 4'h2);
		exp_q.push_back(uv(7));
		apb(1'b1, irq_prio_pkg::OFS_FORCE, 32'h0000_1000);
		drain();
		// Two requests at once; the last pass shares one level
		for (int i = 0; i < 4; i++) begin
			dly <= 4'($random(seed));
			ia = $random(seed) & 7;
			ib = (ia + 1 + ($random(seed) & 3)) % 8;
			la = ($random(seed) & 255) % 12;
			lb = (i == 3) ? la : (la + 1 + ($random(seed) & 7)) % 12;
			pw = irq_prio_pkg::PRIO0_RESET;
			pw[4*ia +: 4] = 4'(la);
			pw[4*ib +: 4] = 4'(lb);
			apb(1'b1, irq_prio_pkg::OFS_PRIO0, pw);
			m = '0;
			m[ia] = 1'b1;
			m[ib] = 1'b1;
			exp_q.push_back(uv(la < lb ? la : lb));
			if (la != lb) exp_q.push_back(uv(la < lb ? lb : la));
			pulse(m, 4'h0);
			drain();
		end
		flag_in[0] <= 1'b0;
		apb(1'b1, irq_prio_pkg::OFS_FLAGDIR, 32'h0000_0002);
		apb(1'b1, irq_prio_pkg::OFS_FLAGOUT, 32'h0000_0002);
		apb(1'b1, irq_prio_pkg::OFS_FLAGMOD, 32'h0000_0001);
		apb(1'b1, irq_prio_pkg::OFS_FLAGAB, 32'h0000_0001);
		`chk("flag out", 16'h0002, fo)
		`chk("flag oe_n", 16'hFFFD, foe)
		exp_q.push_back(uv(11));
		flag_in[0] <= 1'b1;
		drain();
		apb(1'b1, irq_prio_pkg::OFS_INTERRUPT_MASK_REGISTER, 32'h0000_0003);
		repeat (3) @(posedge pclk);
		`chk("irq set", 1'b1, irq)
		apb(1'b1, irq_prio_pkg::OFS_ISTAT, 32'h0000_0003);
		repeat (3) @(posedge pclk);
		`chk("irq clear", 1'b0, irq)
		test_done();
	end
endmodule // tb_dsp_interrupt_prioritizer
`default_nettype wire
